// ===== rtl/sfct_core.sv
// Serial flash command decoder, framing and busy sequencing
`timescale 1ns/100ps
module sfct_core
#(
   parameter int XFER_CYCLES = sfct_pkg::XFER_CYCLES,
   parameter int EP_CYCLES   = sfct_pkg::EP_CYCLES,
   parameter int P_CYCLES    = sfct_pkg::P_CYCLES,
   parameter int PE_CYCLES   = sfct_pkg::PE_CYCLES,
   parameter int BE_CYCLES   = sfct_pkg::BE_CYCLES,
   parameter bit LARGE_PART  = 1'b0
)
(
   // System clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   // Serial link, serial clock domain
   input  wire logic                   sck,
   input  wire logic                   cs_n,
   input  wire logic                   si,
   output logic                        so,
   output logic                        so_oe,
   // Ready/busy pin
   output logic                        ready_busy_n,
   // Array data source
   input  wire logic [7:0]             rd_data,
   // Decoded command and state
   output sfct_pkg::sfct_cmd_type       cmd,
   output logic [4:0]                  sector
);

   // ----------------------------------------------------------------
   // Link side: shift in on rising edge, shift out on falling edge
   // ----------------------------------------------------------------
   // The link clock stops between frames, so all framing restarts on
   // select; nothing here waits for an edge outside a frame.
   logic [2:0]  bit_cnt;
   logic [6:0]  shift_in;
   logic [3:0]  byte_cnt;
   logic [7:0]  opcode;
   logic [23:0] addr;
   logic [7:0]  out_byte;
   logic        out_en;
   logic        lnk_rst;
   logic        busy_sync;
   logic        busy_meta;
   logic        frame_tgl;
   logic        frame_tgl_sync;
   logic        frame_tgl_seen;
   logic        cs_sync;
   logic        cs_seen;
   logic        timer_busy;
   logic        launch;
   sfct_pkg::sfct_job_type job;
   wire  [7:0]  next_byte = {shift_in, si};

   assign lnk_rst = cs_n;

   always_ff @(posedge sck or posedge lnk_rst)
   begin
      if (lnk_rst)
      begin
         bit_cnt  <= 3'h0;
         shift_in <= 7'h00;
         byte_cnt <= 4'h0;
      end
      else
      begin
         shift_in <= next_byte[6:0];
         bit_cnt  <= bit_cnt + 3'h1;
         if (bit_cnt == 3'h7 && byte_cnt != 4'hF)
            byte_cnt <= byte_cnt + 4'h1;
      end
   end

   // Opcode and address outlive select so the system side can still
   // decode them after the frame; select clears the counters, shift and output registers
   always_ff @(posedge sck or negedge rst_n)
   begin
      if (!rst_n)
      begin
         opcode <= 8'h00;
         addr   <= 24'h00_0000;
      end
      else if (bit_cnt == 3'h7)
      begin
         if (byte_cnt == 4'h0)
            opcode <= next_byte;
         else if (byte_cnt <= 4'(sfct_pkg::ADDR_BYTES))
            addr <= {addr[15:0], next_byte};
      end
   end

   // ----------------------------------------------------------------
   // Read decode, link side
   // ----------------------------------------------------------------
   logic is_status;
   logic is_array;
   logic is_page;
   logic is_buf;
   logic [3:0] data_start;

   always_comb
   begin
      is_status = (opcode == sfct_pkg::OP_STATUS_A) ||
                  (opcode == sfct_pkg::OP_STATUS_B);
      is_array  = (opcode == sfct_pkg::OP_ARRAY_READ_A) ||
                  (opcode == sfct_pkg::OP_ARRAY_READ_B);
      is_page   = (opcode == sfct_pkg::OP_PAGE_READ_A) ||
                  (opcode == sfct_pkg::OP_PAGE_READ_B);
      is_buf    = (opcode == sfct_pkg::OP_BUF1_READ_A) ||
                  (opcode == sfct_pkg::OP_BUF2_READ_A) ||
                  (opcode == sfct_pkg::OP_BUF1_READ_B) ||
                  (opcode == sfct_pkg::OP_BUF2_READ_B);
      // Status has no address; page and array reads add 4 don't-care
      // bytes, buffer reads add 1
      if (is_status)
         data_start = 4'h1;
      else if (is_buf)
         data_start = 4'h5;
      else
         data_start = 4'h8;
   end

   // Falling edge drive serves both idle polarities alike
   always_ff @(negedge sck or posedge lnk_rst)
   begin
      if (lnk_rst)
      begin
         out_en   <= 1'b0;
         out_byte <= 8'h00;
      end
      else if (bit_cnt == 3'h0 && byte_cnt >= data_start &&
               (is_status || is_array || is_page || is_buf))
      begin
         out_en   <= 1'b1;
         out_byte <= is_status ?
                     (busy_sync ? 8'h00 : sfct_pkg::STATUS_READY) : rd_data;
      end
      else if (out_en)
         out_byte <= {out_byte[6:0], 1'b0};
   end

   assign so    = out_byte[7];
   assign so_oe = out_en & ~cs_n;

   // Busy level into the link domain
   always_ff @(posedge sck)
   begin
      busy_meta <= timer_busy;
      busy_sync <= busy_meta;
   end

   // ----------------------------------------------------------------
   // Frame end toggle, link side
   // ----------------------------------------------------------------
   // Needs a reset of its own: the link clock is idle during reset
   always_ff @(posedge sck or negedge rst_n)
   begin
      if (!rst_n)
         frame_tgl <= 1'b0;
      else if (bit_cnt == 3'h7 && byte_cnt == 4'(sfct_pkg::ADDR_BYTES))
         frame_tgl <= ~frame_tgl;
   end

   // ----------------------------------------------------------------
   // System side crossing
   // ----------------------------------------------------------------
   sfct_sync #(.RESET_VALUE(1'b1)) u_cs_sync
   (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .din   (cs_n),
      .dout  (cs_sync)
   );

   sfct_sync #(.RESET_VALUE(1'b0)) u_tgl_sync
   (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .din   (frame_tgl),
      .dout  (frame_tgl_sync)
   );

   // Opcode and address are stable once select is high again
   logic [sfct_pkg::PAGE_BITS-1:0] page;
   logic armed;

   always_comb
   begin
      // Larger parts take the reserved bit as page top, so the whole
      // page field moves up one place
      if (LARGE_PART)
         page = addr[23 -: sfct_pkg::PAGE_BITS];
      else
         page = addr[sfct_pkg::PAGE_LSB +: sfct_pkg::PAGE_BITS];
      unique case (opcode)
         sfct_pkg::OP_XFER_BUF1, sfct_pkg::OP_XFER_BUF2,
         sfct_pkg::OP_CMP_BUF1, sfct_pkg::OP_CMP_BUF2 :
            job.kind = sfct_pkg::SFCT_OP_XFER;
         sfct_pkg::OP_EP_BUF1, sfct_pkg::OP_EP_BUF2,
         sfct_pkg::OP_EP_THRU1, sfct_pkg::OP_EP_THRU2 :
            job.kind = sfct_pkg::SFCT_OP_EP;
         sfct_pkg::OP_P_BUF1, sfct_pkg::OP_P_BUF2 :
            job.kind = sfct_pkg::SFCT_OP_P;
         sfct_pkg::OP_PAGE_ERASE :
            job.kind = sfct_pkg::SFCT_OP_PE;
         sfct_pkg::OP_BLOCK_ERASE :
            job.kind = sfct_pkg::SFCT_OP_BE;
         default :
            job.kind = sfct_pkg::SFCT_OP_NONE;
      endcase
      job.page = page;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         cs_seen        <= 1'b1;
         frame_tgl_seen <= 1'b0;
         armed          <= 1'b0;
      end
      else
      begin
         cs_seen        <= cs_sync;
         frame_tgl_seen <= frame_tgl_sync;
         if (frame_tgl_sync != frame_tgl_seen)
            armed <= 1'b1;
         else if (cs_sync && !cs_seen)
            armed <= 1'b0;
      end
   end

   // Launch on select rise; three system cycles is well inside 200 ns
   assign launch = cs_sync && !cs_seen && armed &&
                   job.kind != sfct_pkg::SFCT_OP_NONE;

   sfct_timer
   #(
      .XFER_CYCLES (XFER_CYCLES),
      .EP_CYCLES   (EP_CYCLES),
      .P_CYCLES    (P_CYCLES),
      .PE_CYCLES   (PE_CYCLES),
      .BE_CYCLES   (BE_CYCLES)
   )
   u_timer
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .start   (launch),
      .job     (job),
      .busy    (timer_busy),
      .sector  (sector),
      .done    ()
   );

   assign ready_busy_n = ~timer_busy;

   // ----------------------------------------------------------------
   // Decoded command, registered on select rise
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         cmd <= '0;
      else if (cs_sync && !cs_seen)
      begin
         cmd.valid       <= armed;
         cmd.array_read  <= is_array;
         cmd.page_read   <= is_page;
         cmd.buf_read    <= is_buf;
         cmd.buf_sel     <= opcode[1];
         cmd.status_read <= is_status;
         cmd.page        <= page;
         cmd.byte_addr   <= addr[sfct_pkg::BYTE_ADDR_BITS-1:0];
      end
      else
         cmd.valid <= 1'b0;
   end

endmodule

// ===== rtl/sfct_pkg.sv
// Shared constants and types for the serial flash command and timing block
package sfct_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_MHZ = 200;
   localparam int PAGE_BUFFER_MOVE_TIME_US = 250;
   localparam int ERASE_PROGRAM_TIME_MS = 20;
   localparam int PROGRAM_ONLY_TIME_MS = 14;
   localparam int PAGE_ERASE_TIME_LIMIT_MS = 8;
   localparam int BLOCK_ERASE_TIME_LIMIT_MS = 12;
   localparam int SELECT_HIGH_TO_BUSY_DELAY_NS = 200;
   localparam int ARRAY_STREAM_CLOCK_LIMIT_MHZ = 20;
   // Longest times round down to whole cycles
   localparam int XFER_CYCLES = PAGE_BUFFER_MOVE_TIME_US * SYS_CLK_MHZ;
   localparam int EP_CYCLES = ERASE_PROGRAM_TIME_MS * 1000 * SYS_CLK_MHZ;
   localparam int P_CYCLES = PROGRAM_ONLY_TIME_MS * 1000 * SYS_CLK_MHZ;
   localparam int PE_CYCLES = PAGE_ERASE_TIME_LIMIT_MS * 1000 * SYS_CLK_MHZ;
   localparam int BE_CYCLES = BLOCK_ERASE_TIME_LIMIT_MS * 1000 * SYS_CLK_MHZ;
   localparam int BUSY_DELAY_CYCLES =
      (SELECT_HIGH_TO_BUSY_DELAY_NS * SYS_CLK_MHZ) / 1000;

   // ----------------------------------------------------------------
   // Link framing and address layout
   // ----------------------------------------------------------------
   localparam int BYTE_BITS = 8;
   localparam int ADDR_BYTES = 3;
   localparam int PAGE_BITS = 13;
   localparam int BYTE_ADDR_BITS = 10;
   localparam int PAGE_LSB = 10;
   localparam int SECTOR_SEL_BITS = 4;
   localparam int SECTOR_LOW_BITS = 6;
   localparam logic [7:0] STATUS_READY = 8'h80;

   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_ARRAY_READ_A = 8'h68;
   localparam logic [7:0] OP_ARRAY_READ_B = 8'hE8;
   localparam logic [7:0] OP_PAGE_READ_A = 8'h52;
   localparam logic [7:0] OP_PAGE_READ_B = 8'hD2;
   localparam logic [7:0] OP_BUF1_READ_A = 8'h54;
   localparam logic [7:0] OP_BUF2_READ_A = 8'h56;
   localparam logic [7:0] OP_BUF1_READ_B = 8'hD4;
   localparam logic [7:0] OP_BUF2_READ_B = 8'hD6;
   localparam logic [7:0] OP_STATUS_A = 8'h57;
   localparam logic [7:0] OP_STATUS_B = 8'hD7;
   localparam logic [7:0] OP_XFER_BUF1 = 8'h53;
   localparam logic [7:0] OP_XFER_BUF2 = 8'h55;
   localparam logic [7:0] OP_CMP_BUF1 = 8'h60;
   localparam logic [7:0] OP_CMP_BUF2 = 8'h61;
   localparam logic [7:0] OP_EP_BUF1 = 8'h83;
   localparam logic [7:0] OP_EP_BUF2 = 8'h86;
   localparam logic [7:0] OP_P_BUF1 = 8'h88;
   localparam logic [7:0] OP_P_BUF2 = 8'h89;
   localparam logic [7:0] OP_EP_THRU1 = 8'h82;
   localparam logic [7:0] OP_EP_THRU2 = 8'h85;
   localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      SFCT_OP_NONE  = 3'h0,
      SFCT_OP_XFER  = 3'h1,
      SFCT_OP_EP    = 3'h2,
      SFCT_OP_P     = 3'h3,
      SFCT_OP_PE    = 3'h4,
      SFCT_OP_BE    = 3'h5
   } sfct_op_type;

   typedef struct packed
   {
      sfct_op_type              kind;
      logic [PAGE_BITS-1:0]     page;
   } sfct_job_type;

   typedef struct packed
   {
      logic                     valid;
      logic                     array_read;
      logic                     page_read;
      logic                     buf_read;
      logic                     buf_sel;
      logic                     status_read;
      logic [PAGE_BITS-1:0]     page;
      logic [BYTE_ADDR_BITS-1:0] byte_addr;
   } sfct_cmd_type;

endpackage

// ===== rtl/sfct_sync.sv
// Two-flop synchroniser for single-bit levels
`timescale 1ns/100ps
module sfct_sync
#(
   parameter logic RESET_VALUE = 1'b0
)
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Level
   input  wire logic din,
   output logic      dout
);

   logic stage;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         stage <= RESET_VALUE;
         dout  <= RESET_VALUE;
      end
      else
      begin
         stage <= din;
         dout  <= stage;
      end
   end

endmodule

// ===== rtl/sfct_timer.sv
// Self-timed operation timer with busy output and sector decode
`timescale 1ns/100ps
module sfct_timer
#(
   parameter int XFER_CYCLES = sfct_pkg::XFER_CYCLES,
   parameter int EP_CYCLES   = sfct_pkg::EP_CYCLES,
   parameter int P_CYCLES    = sfct_pkg::P_CYCLES,
   parameter int PE_CYCLES   = sfct_pkg::PE_CYCLES,
   parameter int BE_CYCLES   = sfct_pkg::BE_CYCLES
)
(
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   // Job start
   input  wire logic                  start,
   input  wire sfct_pkg::sfct_job_type job,
   // State
   output logic                       busy,
   output logic [4:0]                 sector,
   output logic                       done
);

   logic [31:0] count;
   logic [31:0] load;

   // ----------------------------------------------------------------
   // Duration per job kind
   // ----------------------------------------------------------------
   always_comb
   begin
      unique case (job.kind)
         sfct_pkg::SFCT_OP_XFER : load = 32'(XFER_CYCLES);
         sfct_pkg::SFCT_OP_EP   : load = 32'(EP_CYCLES);
         sfct_pkg::SFCT_OP_P    : load = 32'(P_CYCLES);
         sfct_pkg::SFCT_OP_PE   : load = 32'(PE_CYCLES);
         sfct_pkg::SFCT_OP_BE   : load = 32'(BE_CYCLES);
         default                : load = 32'h0000_0001;
      endcase
   end

   // ----------------------------------------------------------------
   // Countdown
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         count <= 32'h0000_0000;
         busy  <= 1'b0;
         done  <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start && !busy)
         begin
            count <= load - 32'h0000_0001;
            busy  <= 1'b1;
         end
         else if (busy && count == 32'h0000_0000)
         begin
            busy <= 1'b0;
            done <= 1'b1;
         end
         else if (busy)
            count <= count - 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // Sector of the job page
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         sector <= 5'h00;
      else if (start && !busy)
      begin
         // Pages 0..7 alone form sector 0; the rest of the bottom slice is 1
         if (job.page[sfct_pkg::PAGE_BITS-1:3] == 10'h000)
            sector <= 5'h00;
         else
            sector <= 5'(job.page[sfct_pkg::PAGE_BITS-1 -: 4]) + 5'h01;
      end
   end

endmodule

// ===== bench/sfct_core_asserts.sv
// Port-level checker for the serial flash command block
`timescale 1ns/100ps
module sfct_core_asserts
#(
   parameter int XFER_CYCLES = 20,
   parameter int EP_CYCLES   = 100,
   parameter int P_CYCLES    = 80,
   parameter int PE_CYCLES   = 60,
   parameter int BE_CYCLES   = 40
)
(
   // Clock and reset
   input wire logic                   clk_sys,
   input wire logic                   rst_n,
   // Link
   input wire logic                   sck,
   input wire logic                   cs_n,
   input wire logic                   si,
   input wire logic                   so_oe,
   // State
   input wire logic                   ready_busy_n,
   input wire sfct_pkg::sfct_cmd_type cmd,
   input wire logic [4:0]             sector
);
   // ----------------------------------------------------------------
   // Frame shadow
   // ----------------------------------------------------------------
   logic        sck_q;
   logic        cs_q;
   logic [6:0]  cnt;
   logic [7:0]  op;
   logic [23:0] adr;
   int unsigned lim;
   int unsigned bcnt;
   logic        launch;
   logic [4:0]  esec;

   function automatic int unsigned limit(input logic [7:0] o);
      case (o)
         8'h53, 8'h55, 8'h60, 8'h61: return XFER_CYCLES;
         8'h83, 8'h86, 8'h82, 8'h85: return EP_CYCLES;
         8'h88, 8'h89: return P_CYCLES;
         8'h81: return PE_CYCLES;
         8'h50: return BE_CYCLES;
         default: return 0;
      endcase
   endfunction

   assign launch = (cnt == 7'h20) && (limit(op) != 0);
   assign esec = (adr[22:13] == 10'h000) ? 5'h00 : {1'b0, adr[22:19]} + 5'h01;

   // Oversampling sck is safe: it is far slower than clk_sys
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         sck_q <= 1'b0;
         cs_q <= 1'b1;
         cnt <= 7'h00;
         op <= 8'h00;
         adr <= 24'h000000;
      end
      else
      begin
         sck_q <= sck;
         cs_q <= cs_n;
         if (cs_q && !cs_n)
            cnt <= 7'h00;
         else if (!cs_n && sck && !sck_q)
         begin
            cnt <= cnt + 7'h01;
            if (cnt < 7'h08)
               op <= {op[6:0], si};
            else if (cnt < 7'h20)
               adr <= {adr[22:0], si};
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         lim <= 0;
         bcnt <= 0;
      end
      else
      begin
         if (cs_n && !cs_q && launch)
            lim <= limit(op);
         bcnt <= ready_busy_n ? 0 : bcnt + 1;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_busy_start: assert property (cs_n && !cs_q && launch
      && ready_busy_n |-> ##[1:40] !ready_busy_n)
      else $error("busy late after launch");
   a_busy_cause: assert property ($fell(ready_busy_n)
      |-> cs_n && lim != 0) else $error("busy without a launch");
   a_move_time: assert property (!ready_busy_n && lim == XFER_CYCLES
      |-> bcnt <= XFER_CYCLES + 4) else $error("transfer too long");
   a_prog_time: assert property (!ready_busy_n
      |-> bcnt <= lim + 4) else $error("self-timed job too long");
   a_busy_length: assert property ($rose(ready_busy_n)
      |-> bcnt + 3 >= lim) else $error("busy ended early");
   a_sector_map: assert property (cs_n && !cs_q && launch
      && ready_busy_n |-> ##[1:40] (!ready_busy_n && sector == esec))
      else $error("wrong sector");
   a_cmd_fields: assert property (cmd.valid
      |-> cmd.page == adr[22:10] && cmd.byte_addr == adr[9:0])
      else $error("command address mismatch");
   a_cmd_kind: assert property (cmd.valid
      |-> cmd.array_read == (op == 8'h68 || op == 8'hE8)
      && cmd.page_read == (op == 8'h52 || op == 8'hD2)
      && cmd.buf_read == (op inside {8'h54, 8'h56, 8'hD4, 8'hD6}))
      else $error("command kind mismatch");
   a_opcode_quiet: assert property (!cs_n && cnt < 7'h08
      |-> !so_oe) else $error("output driven during opcode");
   a_drive_cause: assert property (so_oe
      |-> !cs_n && cnt >= 7'h08 && op inside {8'h57, 8'hD7, 8'h68,
      8'hE8, 8'h52, 8'hD2, 8'h54, 8'h56, 8'hD4, 8'hD6})
      else $error("output driven outside a read");
   a_pad_quiet: assert property (!cs_n && (cnt < 7'h40 &&
      op inside {8'h68, 8'hE8, 8'h52, 8'hD2} || cnt < 7'h28 &&
      op inside {8'h54, 8'h56, 8'hD4, 8'hD6}) |-> !so_oe)
      else $error("output driven before the data phase");
endmodule

bind sfct_core sfct_core_asserts
#(
   .XFER_CYCLES (XFER_CYCLES),
   .EP_CYCLES   (EP_CYCLES),
   .P_CYCLES    (P_CYCLES),
   .PE_CYCLES   (PE_CYCLES),
   .BE_CYCLES   (BE_CYCLES)
)
u_chk
(
   .clk_sys      (clk_sys),
   .rst_n        (rst_n),
   .sck          (sck),
   .cs_n         (cs_n),
   .si           (si),
   .so_oe        (so_oe),
   .ready_busy_n (ready_busy_n),
   .cmd          (cmd),
   .sector       (sector)
);

// ===== bench/sfct_host_model.sv
// Host serial master model that frames commands on the link
`timescale 1ns/100ps
module sfct_host_model
(
   // Link outputs
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   // Link inputs
   input  wire logic so,
   input  wire logic so_oe
);
   // 6.25 MHz link clock, well under the ceiling
   localparam realtime HALF = 80.0;

   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end

   // Clock stands still between frames; idle level picks the mode
   task automatic frame(input bit m3, input int nbits,
                        input logic [79:0] tx, output logic [7:0] rx);
      rx = 8'h00;
      sck = m3;
      #251.3;
      cs_n = 1'b0;
      #250;
      for (int i = 0; i < nbits; i++)
      begin
         if (m3)
            sck = 1'b0;
         si = tx[79 - i];
         #HALF;
         sck = 1'b1;
         rx = {rx[6:0], so_oe ? so : 1'bx};
         #HALF;
         if (!m3)
            sck = 1'b0;
      end
      #250;
      cs_n = 1'b1;
      si = ~si;
   endtask
endmodule

// ===== bench/serial_flash_command_timing_test.sv
// Self-checking bench for the serial flash command block
`timescale 1ns/100ps
module serial_flash_command_timing_test;
   // ----------------------------------------------------------------
   // Set-up
   // ----------------------------------------------------------------
   // Short job counts keep the run brief
   localparam int XF = 20;
   localparam int EP = 100;
   localparam int PR = 80;
   localparam int PE = 60;
   localparam int BE = 40;

   logic                   clk_sys;
   logic                   rst_n;
   logic                   sck;
   logic                   cs_n;
   logic                   si;
   logic                   so;
   logic                   so_oe;
   logic                   ready_busy_n;
   logic [7:0]             rd_data;
   logic [4:0]             sector;
   sfct_pkg::sfct_cmd_type cmd;
   sfct_pkg::sfct_cmd_type last_cmd;
   int                     bad_count = 0;
   int                     n_tests = 0;
   int                     n_valid = 0;
   logic [12:0]            refresh_ptr = 13'h0208;
   logic [7:0]  l_op [12] = '{8'h53, 8'h55, 8'h60, 8'h61, 8'h83, 8'h86,
                              8'h82, 8'h85, 8'h88, 8'h89, 8'h81, 8'h50};
   logic [12:0] l_pg [12] = '{13'h0000, 13'h0007, 13'h0008, 13'h01FF,
                              13'h0200, 13'h1FFF, 13'h0E00, 13'h1000,
                              13'h0600, 13'h0A00, 13'h1C00, 13'h0003};
   logic [7:0]  r_op [8] = '{8'h68, 8'hE8, 8'h52, 8'hD2,
                             8'h54, 8'h56, 8'hD4, 8'hD6};
   logic [3:0]  r_fl [8] = '{4'h8, 4'h8, 4'h5, 4'h5, 4'h2, 4'h3, 4'h2, 4'h3};

   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      if (cmd.valid === 1'b1)
      begin
         last_cmd <= cmd;
         n_valid <= n_valid + 1;
      end
   end

   sfct_core
   #(
      .XFER_CYCLES (XF),
      .EP_CYCLES   (EP),
      .P_CYCLES    (PR),
      .PE_CYCLES   (PE),
      .BE_CYCLES   (BE),
      .LARGE_PART  (1'b0)
   )
   uut
   (
      .clk_sys      (clk_sys),
      .rst_n        (rst_n),
      .sck          (sck),
      .cs_n         (cs_n),
      .si           (si),
      .so           (so),
      .so_oe        (so_oe),
      .ready_busy_n (ready_busy_n),
      .rd_data      (rd_data),
      .cmd          (cmd),
      .sector       (sector)
   );

   sfct_host_model host
   (
      .sck   (sck),
      .cs_n  (cs_n),
      .si    (si),
      .so    (so),
      .so_oe (so_oe)
   );

   // ----------------------------------------------------------------
   // Helpers and scenarios
   // ----------------------------------------------------------------
   task automatic wrap_up();
      if (bad_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
         bad_count++;
      end
   endtask

   task automatic wait_rb(input logic lvl, input int lim, output int n);
      n = 0;
      while (ready_busy_n !== lvl)
      begin
         @(negedge clk_sys);
         n++;
         if (n > lim)
         begin
            $display("CHECK FAILED ready_busy_n expected %0b seen %0b",
                     lvl, ready_busy_n);
            bad_count++;
            wrap_up();
         end
      end
   endtask

   function automatic int busy_len(input logic [7:0] op);
      case (op)
         8'h53, 8'h55, 8'h60, 8'h61: return XF;
         8'h88, 8'h89: return PR;
         8'h81: return PE;
         8'h50: return BE;
         default: return EP;
      endcase
   endfunction

   function automatic logic [4:0] exp_sector(input logic [12:0] pg);
      return (pg[12:3] == 10'h000) ? 5'h00 : {1'b0, pg[12:9]} + 5'h01;
   endfunction

   task automatic t_launch(input logic [7:0] op, input logic [12:0] pg,
                           input bit m3);
      logic [7:0] rx;
      int         n;
      int         m;
      int         lim;
      lim = busy_len(op);
      host.frame(m3, 32, {op, 1'b0, pg, 10'h155, 48'h0}, rx);
      wait_rb(1'b0, 60, n);
      check("busy delay", 16'h0001, 16'(n <= 40));
      wait_rb(1'b1, 400, m);
      check("busy length", 16'(lim),
            16'((m >= lim - 1 && m <= lim + 3) ? lim : m));
      check("sector", 16'(exp_sector(pg)), 16'(sector));
   endtask

   task automatic t_read(input logic [7:0] op, input logic [3:0] fl,
                         input bit m3, input int pad);
      logic [7:0] rx;
      logic [7:0] val;
      int         v0;
      int         n;
      val = op ^ 8'h3C;
      @(negedge clk_sys);
      rd_data = val;
      v0 = n_valid;
      host.frame(m3, 8 * (5 + pad), {op, 1'b0, 13'h0ABC, 10'h2D3, 48'h0}, rx);
      check("read data", 16'(val), 16'(rx));
      n = 0;
      while (n_valid == v0 && n < 40)
      begin
         @(negedge clk_sys);
         n++;
      end
      check("cmd valid", 16'h0001, 16'(n < 40));
      check("cmd kind", 16'(fl), 16'({last_cmd.array_read, last_cmd.page_read,
            last_cmd.buf_read, last_cmd.buf_sel}));
      check("cmd page", 16'h0ABC, 16'(last_cmd.page));
      check("cmd byte", 16'h02D3, 16'(last_cmd.byte_addr));
   endtask

   task automatic t_status(input logic [7:0] op, input bit m3);
      logic [7:0] rx;
      host.frame(m3, 16, {op, 72'h0}, rx);
      check("status byte", 16'h0080, 16'(rx));
   endtask

   // Opcode plus two and a half address bytes must not launch a job
   task automatic t_partial();
      logic [7:0] rx;
      host.frame(1'b0, 28, {8'h81, 72'h0}, rx);
      repeat (60) @(negedge clk_sys);
      check("partial frame", 16'h0001, 16'(ready_busy_n));
   endtask

   initial
   begin
      rst_n = 1'b0;
      rd_data = 8'h00;
      repeat (12) @(negedge clk_sys);
      rst_n = 1'b1;
      check("ready after reset", 16'h0001, 16'(ready_busy_n));
      repeat (4) @(negedge clk_sys);
      for (int i = 0; i < 12; i++)
         t_launch(l_op[i], l_pg[i], i[0]);
      // Refresh rewrites follow the pointer, one page per pass
      for (int i = 0; i < 2; i++)
      begin
         t_launch(8'h83, refresh_ptr, i[0]);
         refresh_ptr = refresh_ptr + 13'h0001;
      end
      for (int i = 0; i < 8; i++)
         t_read(r_op[i], r_fl[i], i[0], (i < 4) ? 4 : 1);
      t_status(8'h57, 1'b0);
      t_status(8'h57, 1'b1);
      t_status(8'hD7, 1'b0);
      t_status(8'hD7, 1'b1);
      t_partial();
      wrap_up();
   end
endmodule
